// ---- rtl/occ_clock_control.sv ----
`timescale 1ns/1ns
module occ_clock_control (
    // clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [occ_pkg::WB_AW-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // oscillator status pins
    input wire logic rcOscStable,
    input wire logic extOscStable,
    input wire logic pllLocked,
    input wire logic extOscFail,
    input wire logic [occ_pkg::CAL_W-1:0] calibrationIn,
    // system clock state and power events, same clock
    input wire logic [1:0] sysClkSel,
    input wire logic pllSrcExt,
    input wire logic lowPowerEntry,
    input wire logic lowPowerWake,
    // oscillator controls and interrupt
    output logic rcOscEnable,
    output logic extOscEnable,
    output logic extOscBypass,
    output logic pllEnable,
    output logic clockFailureDetectActive,
    output logic [occ_pkg::CAL_W-1:0] rcOscTuning,
    output logic irq
);
    import occ_pkg::*;

    // ----------------------------------------
    // input synchronisers
    // ----------------------------------------
    logic [NSRC:0] pinSync1_reg, pinSync2_reg;
    logic [CAL_W-1:0] calSync1_reg, calSync2_reg;
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            // idle levels match the flag resets, no false edge after reset
            pinSync1_reg <= {1'b0, READY_RESET};
            pinSync2_reg <= {1'b0, READY_RESET};
            calSync1_reg <= '0;
            calSync2_reg <= '0;
        end else begin
            pinSync1_reg <= {extOscFail, pllLocked, extOscStable, rcOscStable};
            pinSync2_reg <= pinSync1_reg;
            calSync1_reg <= calibrationIn;
            calSync2_reg <= calSync1_reg;
        end
    end
    wire [NSRC-1:0] stable = pinSync2_reg[NSRC-1:0];
    wire failPin = pinSync2_reg[NSRC];

    // ----------------------------------------
    // bus decode
    // ----------------------------------------
    logic ack_reg;
    logic [31:0] rdat_reg;
    wire request = wb_cyc_i & wb_stb_i;
    wire wrStrobe = request & wb_we_i & ack_reg;
    wire selCtrl = wb_adr_i == OFS_CTRL;
    wire selStat = wb_adr_i == OFS_IRQ_STATUS;
    wire selMask = wb_adr_i == OFS_IRQ_MASK;
    wire wrCtrl0 = wrStrobe & selCtrl & wb_sel_i[0];
    wire wrCtrl2 = wrStrobe & selCtrl & wb_sel_i[2];
    wire wrCtrl3 = wrStrobe & selCtrl & wb_sel_i[3];
    wire wrStat = wrStrobe & selStat & wb_sel_i[0];
    wire wrMask = wrStrobe & selMask & wb_sel_i[0];

    // ----------------------------------------
    // control bits
    // ----------------------------------------
    logic rcEn_reg, extEn_reg, extBp_reg, cfdEn_reg, pll_enable_reg;
    logic [TRIM_W-1:0] trim_reg;
    logic [CAL_W-1:0] cal_reg;
    logic [1:0] calLoad_reg;
    logic [NSRC-1:0] ready_reg;
    logic cfdActive_reg;

    wire pllOnSys = sysClkSel == SYS_PLL;
    wire rcInUse = (sysClkSel == SYS_RC) | (pllOnSys & ~pllSrcExt);
    wire extInUse = (sysClkSel == SYS_EXT) | (pllOnSys & pllSrcExt);
    wire failEvent = failPin & cfdActive_reg;

    wire rcEnNext = (lowPowerWake | failEvent) ? 1'b1 :
        (wrCtrl0 & (wb_dat_i[BIT_RC_EN] | ~rcInUse)) ?
        wb_dat_i[BIT_RC_EN] : rcEn_reg;
    wire extEnNext = lowPowerEntry ? 1'b0 :
        (wrCtrl2 & (wb_dat_i[BIT_EXT_EN] | ~extInUse)) ?
        wb_dat_i[BIT_EXT_EN] : extEn_reg;
    wire pllEnNext = lowPowerEntry ? 1'b0 :
        (wrCtrl3 & (wb_dat_i[BIT_PLL_EN] | ~pllOnSys)) ?
        wb_dat_i[BIT_PLL_EN] : pll_enable_reg;
    wire bpWrite = wrCtrl2 & ~extEn_reg;

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            rcEn_reg <= CTRL_RESET[BIT_RC_EN];
            extEn_reg <= CTRL_RESET[BIT_EXT_EN];
            extBp_reg <= CTRL_RESET[BIT_EXT_BP];
            cfdEn_reg <= CTRL_RESET[BIT_CFD_EN];
            pll_enable_reg <= CTRL_RESET[BIT_PLL_EN];
            trim_reg <= TRIM_RESET;
        end else begin
            rcEn_reg <= rcEnNext;
            extEn_reg <= extEnNext;
            pll_enable_reg <= pllEnNext;
            if (bpWrite) begin
                extBp_reg <= wb_dat_i[BIT_EXT_BP];
            end
            if (wrCtrl2) begin
                cfdEn_reg <= wb_dat_i[BIT_CFD_EN];
            end
            if (wrCtrl0) begin
                trim_reg <= wb_dat_i[TRIM_LSB +: TRIM_W];
            end
        end
    end

    // ----------------------------------------
    // calibration load after reset release
    // ----------------------------------------
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            cal_reg <= CAL_RESET;
            calLoad_reg <= '0;
        end else if (calLoad_reg != CAL_LOAD_DONE) begin
            calLoad_reg <= calLoad_reg + 2'h1;
            if (calLoad_reg == CAL_LOAD_DONE - 2'h1) begin
                cal_reg <= calSync2_reg;
            end
        end
    end

    // ----------------------------------------
    // ready flags with off delay
    // ----------------------------------------
    wire [NSRC-1:0] srcEn = {pll_enable_reg, extEn_reg, rcEn_reg};
    logic [NSRC-1:0] readyNext;
    genvar g;
    generate
        for (g = 0; g < NSRC; g++) begin : gReady
            logic [7:0] offCnt_reg;
            wire counting = offCnt_reg != 8'h00;
            assign readyNext[g] = srcEn[g] ? stable[g] :
                (counting & ready_reg[g] & stable[g]);
            always_ff @(posedge core_clk or negedge arst_n) begin
                if (!arst_n) begin
                    offCnt_reg <= '0;
                    ready_reg[g] <= READY_RESET[g];
                end else begin
                    ready_reg[g] <= readyNext[g];
                    if (srcEn[g]) begin
                        offCnt_reg <= OFF_CLKS[g];
                    end else if (counting) begin
                        offCnt_reg <= offCnt_reg - 8'h01;
                    end
                end
            end
        end
    endgenerate

    // ----------------------------------------
    // failure detector and tuning output
    // ----------------------------------------
    logic [CAL_W-1:0] tune_reg;
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            cfdActive_reg <= 1'b0;
            tune_reg <= '0;
        end else begin
            cfdActive_reg <= cfdEn_reg & ready_reg[1];
            tune_reg <= cal_reg + CAL_W'(trim_reg);
        end
    end

    // ----------------------------------------
    // interrupt status and mask
    // ----------------------------------------
    logic [IRQ_W-1:0] status_reg, mask_reg;
    logic irq_reg;
    wire [IRQ_W-1:0] events = {failEvent, readyNext & ~ready_reg};
    wire [IRQ_W-1:0] statusNext = events |
        (status_reg & ~({IRQ_W{wrStat}} & wb_dat_i[IRQ_W-1:0]));
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            status_reg <= '0;
            mask_reg <= '0;
            irq_reg <= 1'b0;
        end else begin
            status_reg <= statusNext;
            irq_reg <= |(statusNext & mask_reg);
            if (wrMask) begin
                mask_reg <= wb_dat_i[IRQ_W-1:0];
            end
        end
    end

    // ----------------------------------------
    // read mux and acknowledge
    // ----------------------------------------
    // read-only fields ignore writes
    wire [31:0] ctrlView = {6'h00, ready_reg[2], pll_enable_reg, 4'h0,
        cfdEn_reg, extBp_reg, ready_reg[1], extEn_reg, cal_reg,
        trim_reg, 1'b0, ready_reg[0], rcEn_reg};
    wire [31:0] readMux = selCtrl ? ctrlView :
        selStat ? {{(32-IRQ_W){1'b0}}, status_reg} :
        selMask ? {{(32-IRQ_W){1'b0}}, mask_reg} : 32'h0000_0000;
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            ack_reg <= 1'b0;
            rdat_reg <= '0;
        end else begin
            ack_reg <= request & ~ack_reg;
            if (request & ~ack_reg) begin
                rdat_reg <= readMux;
            end
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = rdat_reg;
    assign rcOscEnable = rcEn_reg;
    assign extOscEnable = extEn_reg;
    assign extOscBypass = extBp_reg;
    assign pllEnable = pll_enable_reg;
    assign clockFailureDetectActive = cfdActive_reg;
    assign rcOscTuning = tune_reg;
    assign irq = irq_reg;
endmodule

// ---- rtl/occ_pkg.sv ----
package occ_pkg;
    localparam int WB_AW = 4;
    localparam logic [3:0] OFS_CTRL = 4'h0;
    localparam logic [3:0] OFS_IRQ_STATUS = 4'h4;
    localparam logic [3:0] OFS_IRQ_MASK = 4'h8;
    localparam logic [31:0] CTRL_RESET = 32'h0000_7783;
    localparam int BIT_RC_EN = 0;
    localparam int BIT_RC_RDY = 1;
    localparam int TRIM_LSB = 3;
    localparam int TRIM_W = 5;
    localparam int CAL_LSB = 8;
    localparam int CAL_W = 8;
    localparam int BIT_EXT_EN = 16;
    localparam int BIT_EXT_RDY = 17;
    localparam int BIT_EXT_BP = 18;
    localparam int BIT_CFD_EN = 19;
    localparam int BIT_PLL_EN = 24;
    localparam int BIT_PLL_RDY = 25;
    localparam logic [4:0] TRIM_RESET = 5'h10;
    localparam logic [7:0] CAL_RESET = 8'h77;
    // source index: 0 rc, 1 ext, 2 pll
    localparam int NSRC = 3;
    localparam logic [2:0] READY_RESET = 3'h1;
    localparam logic [1:0] SYS_RC = 2'h0;
    localparam logic [1:0] SYS_EXT = 2'h1;
    localparam logic [1:0] SYS_PLL = 2'h2;
    localparam int IRQ_W = 4;
    localparam int IRQ_FAIL = 3;
    localparam int CORE_PERIOD_NS = 20;
    localparam int OSC_OFF_CYCLES = 6;
    localparam int RC_OSC_KHZ = 8000;
    localparam int EXT_OSC_KHZ = 8000;
    localparam int RC_OFF_NS = OSC_OFF_CYCLES * 1000000 / RC_OSC_KHZ;
    localparam int EXT_OFF_NS = OSC_OFF_CYCLES * 1000000 / EXT_OSC_KHZ;
    localparam int RC_OFF_CLKS =
        (RC_OFF_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
    localparam int EXT_OFF_CLKS =
        (EXT_OFF_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
    localparam int PLL_OFF_CLKS = 1;
    localparam logic [7:0] OFF_CLKS [NSRC] = '{
        8'(RC_OFF_CLKS), 8'(EXT_OFF_CLKS), 8'(PLL_OFF_CLKS)};
    localparam logic [1:0] CAL_LOAD_DONE = 2'h3;
endpackage

// ---- tb/occ_clock_control_assertions.sv ----
`timescale 1ns/1ns
module occ_clock_control_checker (
    // clock and bus
    input wire logic core_clk, arst_n, wb_cyc_i, wb_stb_i, wb_ack_o,
    // pins and events
    input wire logic extOscStable, pllSrcExt, lowPowerEntry, lowPowerWake,
    input wire logic [1:0] sysClkSel,
    // controls
    input wire logic rcOscEnable, extOscEnable, extOscBypass, pllEnable,
    input wire logic clockFailureDetectActive
);
    import occ_pkg::*;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    wire logic isPll = sysClkSel == SYS_PLL;
    wire logic rcUse = sysClkSel == SYS_RC || (isPll && !pllSrcExt);
    wire logic extUse = sysClkSel == SYS_EXT || (isPll && pllSrcExt);
    sequence extLost; (!extOscStable) [*5]; endsequence
    sequence newReq; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
    a_ack_next: assert property (newReq |=> wb_ack_o)
        else $error("ack missing");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack too long");
    a_pll_lp_clear: assert property (
        lowPowerEntry |-> ##[1:2] !pllEnable) else $error("pll kept");
    a_ext_lp_clear: assert property (
        lowPowerEntry |-> ##[1:2] !extOscEnable) else $error("ext kept");
    a_rc_wake_set: assert property (
        lowPowerWake |-> ##[1:2] rcOscEnable) else $error("rc not set");
    a_pll_hold: assert property (
        isPll && pllEnable && !lowPowerEntry |=> pllEnable)
        else $error("pll dropped");
    a_ext_hold: assert property (
        extUse && extOscEnable && !lowPowerEntry |=> extOscEnable)
        else $error("ext dropped");
    a_rc_hold: assert property (rcUse && rcOscEnable |=> rcOscEnable)
        else $error("rc dropped");
    a_bypass_lock: assert property (
        extOscEnable |=> $stable(extOscBypass)) else $error("bypass moved");
    a_cfd_off: assert property (extLost |-> !clockFailureDetectActive)
        else $error("detector active");
endmodule
bind occ_clock_control occ_clock_control_checker u_chk (.core_clk, .arst_n,
    .wb_cyc_i, .wb_stb_i, .wb_ack_o, .extOscStable, .pllSrcExt, .lowPowerEntry,
    .lowPowerWake, .sysClkSel, .rcOscEnable, .extOscEnable, .extOscBypass,
    .pllEnable, .clockFailureDetectActive);

// ---- tb/testbench.sv ----
`timescale 1ns/1ns
module testbench;
    import occ_pkg::*;
    logic core_clk, arst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq;
    logic [WB_AW-1:0] wb_adr_i;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o;
    logic rcOscStable, extOscStable, pllLocked, extOscFail, pllSrcExt;
    logic lowPowerEntry, lowPowerWake, rcOscEnable, extOscEnable;
    logic extOscBypass, pllEnable, clockFailureDetectActive;
    logic [1:0] sysClkSel;
    logic [7:0] calibrationIn, rcOscTuning, seed;
    logic [4:0] trim;
    logic [31:0] expQ[$];
    int num_errors = 0;
    int comparisons = 0;
    occ_clock_control dut (.core_clk, .arst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i,
        .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .rcOscStable,
        .extOscStable, .pllLocked, .extOscFail, .calibrationIn, .sysClkSel,
        .pllSrcExt, .lowPowerEntry, .lowPowerWake, .rcOscEnable, .extOscEnable,
        .extOscBypass, .pllEnable, .clockFailureDetectActive, .rcOscTuning,
        .irq);
    initial begin
        core_clk = 0;
        forever #10 core_clk = ~core_clk;
    end
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    function automatic logic [31:0] f(input logic [31:0] hi);
        return hi | {16'h0, calibrationIn, trim, 3'h0};
    endfunction
    task automatic bad(input string m);
        num_errors++;
        $display("unexpected at %0t: %s", $time, m);
    endtask
    task automatic conclude;
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input logic a, input logic e, input string m);
        comparisons++;
        if (a !== e) bad(m);
    endtask
    task automatic cmp_rd;
        comparisons++;
        if (expQ.size() == 0 || wb_dat_o !== expQ[0]) bad("read data");
        if (expQ.size() != 0) void'(expQ.pop_front());
    endtask
    // ----------------------------------------
    // read checker
    // ----------------------------------------
    always @(posedge core_clk) if (wb_ack_o === 1'b1 && !wb_we_i) cmp_rd();
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        wb_cyc_i <= 1;
        wb_stb_i <= 1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do begin
            @(posedge core_clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        if (n >= 20) begin
            bad("no ack");
            conclude();
        end
        wb_cyc_i <= 0;
        wb_stb_i <= 0;
        wb_we_i <= 0;
        @(posedge core_clk);
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        expQ.push_back(e);
        bus(0, a, 32'h0);
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        bus(1, a, d);
    endtask
    task automatic mid;
        @(negedge core_clk);
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        {wb_cyc_i, wb_stb_i, wb_we_i, extOscStable, pllLocked} = '0;
        {extOscFail, pllSrcExt, lowPowerEntry, lowPowerWake} = '0;
        {wb_adr_i, wb_dat_i} = '0;
        wb_sel_i = 4'hf;
        sysClkSel = SYS_RC;
        rcOscStable = 1;
        seed = lfsr(8'h17);
        calibrationIn = seed;
        trim = 5'h10;
        arst_n = 0;
        repeat (4) @(posedge core_clk);
        chk(rcOscEnable, 1, "rc reset");
        chk(pllEnable | extOscEnable, 0, "enables reset");
        arst_n <= 1;
        repeat (10) @(posedge core_clk);
        rd(OFS_CTRL, f(32'h3));
        repeat (3) begin
            seed = lfsr(seed);
            trim = seed[4:0];
            wr(OFS_CTRL, 32'h0200_ff03 | {trim, 3'h0});
            rd(OFS_CTRL, f(32'h3));
            mid();
            chk(rcOscTuning === calibrationIn + 8'(trim), 1, "tuning");
            @(posedge core_clk);
        end
        extOscStable <= 1;
        wr(OFS_CTRL, f(32'h0004_0001));
        wr(OFS_CTRL, f(32'h0005_0001));
        wr(OFS_CTRL, f(32'h0001_0001));
        rd(OFS_CTRL, f(32'h0007_0003));
        rd(OFS_IRQ_STATUS, 32'h2);
        chk(irq, 0, "irq masked");
        wr(OFS_IRQ_MASK, 32'hf);
        mid();
        chk(irq, 1, "irq raised");
        @(posedge core_clk);
        wr(OFS_IRQ_STATUS, 32'h2);
        rd(OFS_IRQ_STATUS, 32'h0);
        chk(irq, 0, "irq cleared");
        wr(OFS_CTRL, f(32'h000d_0001));
        repeat (4) @(posedge core_clk);
        chk(clockFailureDetectActive, 1, "detector");
        sysClkSel <= SYS_EXT;
        wr(OFS_CTRL, f(32'h000d_0000));
        chk(rcOscEnable, 0, "rc clear");
        repeat (10) @(posedge core_clk);
        rd(OFS_CTRL, f(32'h000f_0002));
        repeat (40) @(posedge core_clk);
        rd(OFS_CTRL, f(32'h000f_0000));
        wr(OFS_CTRL, f(32'h0008_0000));
        chk(extOscEnable, 1, "ext refused");
        extOscFail <= 1;
        repeat (8) @(posedge core_clk);
        extOscFail <= 0;
        chk(rcOscEnable, 1, "rc on failure");
        rd(OFS_IRQ_STATUS, 32'h9);
        wr(OFS_IRQ_STATUS, 32'hf);
        sysClkSel <= SYS_PLL;
        pllSrcExt <= 1;
        pllLocked <= 1;
        wr(OFS_CTRL, f(32'h010d_0001));
        repeat (5) @(posedge core_clk);
        rd(OFS_CTRL, f(32'h030f_0003));
        wr(OFS_CTRL, f(32'h0008_0000));
        chk(pllEnable, 1, "pll refused");
        chk(extOscEnable, 1, "ext via pll");
        chk(rcOscEnable, 0, "rc free");
        lowPowerEntry <= 1;
        @(posedge core_clk);
        lowPowerEntry <= 0;
        lowPowerWake <= 1;
        @(posedge core_clk);
        lowPowerWake <= 0;
        repeat (2) @(posedge core_clk);
        chk(pllEnable | extOscEnable, 0, "low power");
        chk(rcOscEnable, 1, "wake");
        rd(4'hc, 32'h0);
        conclude();
    end
endmodule
